// file: addr_pin_ctrl.sv
// One shared low address pin: strap input during reset, address output afterwards, floated when strapped high in low power
`timescale 1ns/1ps
module addr_pin_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic addr_bit,
    input wire logic strap_bit,
    input wire logic low_power,
    output logic pin_out,
    output logic pin_oe_n,
    output logic pulldown_en
);
    pin_strap_pkg::pin_phase_e phase;
    pin_strap_pkg::pin_phase_e next_phase;
    logic next_pin_out;
    logic next_pin_oe_n;
    logic next_pulldown_en;

    always_comb begin
        next_phase = phase;
        next_pin_out = addr_bit;
        next_pin_oe_n = 1'b0;
        next_pulldown_en = 1'b0;
        case (phase)
            pin_strap_pkg::PH_STRAP: begin
                next_phase = pin_strap_pkg::PH_ADDR;
            end
            pin_strap_pkg::PH_ADDR: begin
                // Float only if strapped high, else behave like upper address pins
                if (strap_bit && low_power) begin
                    next_pin_oe_n = 1'b1;
                end else begin
                    next_pin_oe_n = 1'b0;
                end
            end
            default: begin
                next_phase = pin_strap_pkg::PH_ADDR;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase <= pin_strap_pkg::PH_STRAP;
            pin_out <= 1'b0;
            pin_oe_n <= 1'b1;
            pulldown_en <= 1'b1;
        end else begin
            phase <= next_phase;
            pin_out <= next_pin_out;
            pin_oe_n <= next_pin_oe_n;
            pulldown_en <= next_pulldown_en;
        end
    end
endmodule

// file: ext_prog_mem.sv
// External program memory and board strap model
`timescale 1ns/1ps
module ext_prog_mem (
    input wire logic clk,
    input wire logic [12:0] addr_upper,
    input wire logic [2:0] addr_low,
    input wire logic [2:0] low_oe_n,
    input wire logic [2:0] pd_on,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe_n,
    input wire logic strap_en,
    input wire logic [2:0] strap_val,
    output logic [2:0] low_pin,
    output logic [7:0] data_pin
);
    logic [7:0] mem [0:255];
    logic [7:0] a;
    assign a = {addr_upper[4:0], low_pin};
    // Open pins with no pull or strap drive show the inverse, never a stale level
    assign low_pin = (~low_oe_n & addr_low) | (low_oe_n & (strap_en ? strap_val : ~pd_on & ~addr_low));
    assign data_pin = data_oe_n == 8'h00 ? data_out : mem[a];
    always @(posedge clk) begin
        if (data_oe_n == 8'h00) mem[a] <= data_out;
    end
endmodule

// file: pin_strap_pkg.sv
// Constants, register layout and types for the strap and program memory pin block
package pin_strap_pkg;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] STATUS_OFFSET = 8'h04;

    // Control register fields
    localparam int CTRL_ROM_SEL_BIT = 0;
    localparam int CTRL_CPU_IDLE_BIT = 1;
    localparam int CTRL_CLK_SLEEP_BIT = 2;
    localparam logic [2:0] CTRL_RESET = 3'h1;

    // Status register fields
    localparam int STAT_STRAP_LSB = 0;
    localparam int STAT_EXT_CLK_BIT = 3;
    localparam int STAT_FREQ48_BIT = 4;
    localparam int STAT_FREQ_RSVD_BIT = 5;
    localparam int STAT_LOW_POWER_BIT = 6;
    localparam int STAT_VALID_BIT = 7;

    // Strap layout and encodings
    localparam int STRAP_WIDTH = 3;
    localparam int CLKDRV_BIT = 2;
    localparam logic [1:0] FREQ_24MHZ = 2'h0;
    localparam logic [1:0] FREQ_48MHZ = 2'h3;
    localparam logic CLKDRV_CRYSTAL = 1'h0;

    // Bus widths
    localparam int ADDR_UPPER_WIDTH = 13;
    localparam int DATA_WIDTH = 8;

    typedef enum logic [1:0] {
        PH_STRAP = 2'b01,
        PH_ADDR = 2'b10
    } pin_phase_e;
endpackage

// file: prog_mem_pin_checker.sv
// Port assertions for the strap and program memory pin block
`timescale 1ns/1ps
module prog_mem_pin_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic wake_irq_line,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_write,
    input wire logic [12:0] prog_mem_addr_upper,
    input wire logic [2:0] prog_mem_addr_low_in,
    input wire logic [2:0] prog_mem_addr_low_out,
    input wire logic [2:0] prog_mem_addr_low_oe_n,
    input wire logic [2:0] strap_pulldown_en,
    input wire logic [7:0] prog_mem_data_bus_oe_n,
    input wire logic ext_clock_select,
    input wire logic clock_48mhz_select,
    input wire logic crystal_osc_enable
);
    logic [2:0] ctrl;
    logic [2:0] strap_q;
    logic [1:0] since;
    logic lp;
    assign lp = ext_clock_select && ctrl[1] && ctrl[2] && !wake_irq_line;
    // Shadow of the control word, taken on the accepting edge
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ctrl <= 3'h1;
            since <= 2'h0;
        end else begin
            if (psel && penable && !pready && pwrite && paddr == 8'h00) ctrl <= pwdata[2:0];
            if (since != 2'h3) since <= since + 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset) strap_q <= prog_mem_addr_low_in;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    pd_reset_a: assert property ($fell(reset) |-> strap_pulldown_en == 3'h7 && prog_mem_addr_low_oe_n == 3'h7)
        else $error("pull-down or float missing in reset");
    pd_release_a: assert property ($fell(reset) |-> ##2 strap_pulldown_en == 3'h0)
        else $error("pull-down kept after reset");
    clock_sel_a: assert property (since == 2'h3 |-> ext_clock_select == strap_q[2] &&
        clock_48mhz_select == (strap_q == 3'h7) && crystal_osc_enable == !strap_q[2]) else $error("clock select wrong");
    upper_addr_a: assert property (since != 2'h0 |-> prog_mem_addr_upper == $past(cpu_addr[15:3]))
        else $error("upper address wrong");
    addr_bit2_a: assert property (since == 2'h3 && !ext_clock_select |->
        !prog_mem_addr_low_oe_n[2] && prog_mem_addr_low_out[2] == $past(cpu_addr[2])) else $error("bit 2 not driven");
    float_bit2_a: assert property (since == 2'h3 |-> prog_mem_addr_low_oe_n[2] == $past(lp))
        else $error("bit 2 float wrong");
    data_drive_a: assert property (!ctrl[0] && cpu_write |=> prog_mem_data_bus_oe_n == 8'h00)
        else $error("data bus not driven");
    data_hold_a: assert property (ctrl[0] |=> prog_mem_data_bus_oe_n == 8'hff)
        else $error("data bus driven with internal rom");
    apb_answer_a: assert property (psel && penable && !pready |=>
        pready && pslverr == !($past(paddr) inside {8'h00, 8'h04})) else $error("bus answer wrong");
endmodule

// file: prog_mem_pin_ctrl.sv
// Clock strap capture and external program memory pin control with APB registers
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
// Behaviour
// - The three low address pins are sampled during reset and held at release to choose clock source and rate.
// - A clock drive strap of 0 means crystal at 24MHz only, 1 means external clock at 24MHz or 48MHz.
// - During reset the clock drive strap pin has a weak pull-down so it reads 0 unless driven high.
// - After reset the pull-down is released and the pin drives address bit 2 again.
// - With drive strap 1, address bit 2 floats while idle is set, wake line is low and sleep is set.
// - With drive strap 0, address bit 2 is always driven like the upper address bits outside reset.
// - With the internal ROM select at 0 the eight-bit data bus moves data between CPU and external memory.
// - Address bits 15 to 3 go out on dedicated output pins.
// - The frequency strap on address bits 1 and 0 gives 24MHz for 00 and 48MHz for 11, others reserved.
module prog_mem_pin_ctrl (
    input wire logic clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic wake_irq_line,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic cpu_write,
    output logic [7:0] cpu_rdata,
    output logic [12:0] prog_mem_addr_upper,
    input wire logic [2:0] prog_mem_addr_low_in,
    output logic [2:0] prog_mem_addr_low_out,
    output logic [2:0] prog_mem_addr_low_oe_n,
    output logic [2:0] strap_pulldown_en,
    input wire logic [7:0] prog_mem_data_bus_in,
    output logic [7:0] prog_mem_data_bus_out,
    output logic [7:0] prog_mem_data_bus_oe_n,
    output logic ext_clock_select,
    output logic clock_48mhz_select,
    output logic crystal_osc_enable
);
    // Strap capture, no async reset: the pins are only meaningful while reset is held
    logic [2:0] strap;
    logic strap_valid;
    logic next_strap_valid;

    // Control register bits
    logic internal_rom_select;
    logic cpu_idle;
    logic clock_sleep;
    logic next_internal_rom_select;
    logic next_cpu_idle;
    logic next_clock_sleep;

    // Bus answer
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;

    // Memory side
    logic [12:0] next_addr_upper;
    logic [7:0] next_cpu_rdata;
    logic [7:0] next_data_out;
    logic [7:0] next_data_oe_n;
    logic low_power;

    // Clock selection
    logic next_ext_clock_select;
    logic next_clock_48mhz_select;
    logic next_crystal_osc_enable;
    logic freq_reserved;

    logic apb_access;
    logic apb_write;

    always_ff @(posedge clk) begin
        if (reset) begin
            strap <= prog_mem_addr_low_in;
        end
    end

    always_comb begin
        next_strap_valid = 1'b1;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            strap_valid <= 1'b0;
        end else begin
            strap_valid <= next_strap_valid;
        end
    end

    // Low power condition shared by all three strap pins
    assign low_power = cpu_idle && !wake_irq_line && clock_sleep;

    genvar gi;
    generate
        for (gi = 0; gi < pin_strap_pkg::STRAP_WIDTH; gi++) begin : g_low_pin
            addr_pin_ctrl u_pin (
                .clk(clk),
                .reset(reset),
                .addr_bit(cpu_addr[gi]),
                .strap_bit(strap[gi]),
                .low_power(low_power),
                .pin_out(prog_mem_addr_low_out[gi]),
                .pin_oe_n(prog_mem_addr_low_oe_n[gi]),
                .pulldown_en(strap_pulldown_en[gi])
            );
        end
    endgenerate

    // APB slave, one wait state so pready comes from a flop
    assign apb_access = psel && penable && !pready;
    assign apb_write = apb_access && pwrite;

    always_comb begin
        next_internal_rom_select = internal_rom_select;
        next_cpu_idle = cpu_idle;
        next_clock_sleep = clock_sleep;
        next_prdata = 32'h0;
        next_pready = apb_access;
        next_pslverr = 1'b0;
        if (apb_access) begin
            if (paddr == pin_strap_pkg::CTRL_OFFSET) begin
                if (apb_write) begin
                    next_internal_rom_select = pwdata[pin_strap_pkg::CTRL_ROM_SEL_BIT];
                    next_cpu_idle = pwdata[pin_strap_pkg::CTRL_CPU_IDLE_BIT];
                    next_clock_sleep = pwdata[pin_strap_pkg::CTRL_CLK_SLEEP_BIT];
                end else begin
                    next_prdata[pin_strap_pkg::CTRL_ROM_SEL_BIT] = internal_rom_select;
                    next_prdata[pin_strap_pkg::CTRL_CPU_IDLE_BIT] = cpu_idle;
                    next_prdata[pin_strap_pkg::CTRL_CLK_SLEEP_BIT] = clock_sleep;
                end
            end else if (paddr == pin_strap_pkg::STATUS_OFFSET) begin
                // Writes here are ignored: straps are read only
                if (!pwrite) begin
                    next_prdata[pin_strap_pkg::STAT_STRAP_LSB +: 3] = strap;
                    next_prdata[pin_strap_pkg::STAT_EXT_CLK_BIT] = ext_clock_select;
                    next_prdata[pin_strap_pkg::STAT_FREQ48_BIT] = clock_48mhz_select;
                    next_prdata[pin_strap_pkg::STAT_FREQ_RSVD_BIT] = freq_reserved;
                    next_prdata[pin_strap_pkg::STAT_LOW_POWER_BIT] = low_power;
                    next_prdata[pin_strap_pkg::STAT_VALID_BIT] = strap_valid;
                end
            end else begin
                next_pslverr = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            internal_rom_select <= pin_strap_pkg::CTRL_RESET[pin_strap_pkg::CTRL_ROM_SEL_BIT];
            cpu_idle <= pin_strap_pkg::CTRL_RESET[pin_strap_pkg::CTRL_CPU_IDLE_BIT];
            clock_sleep <= pin_strap_pkg::CTRL_RESET[pin_strap_pkg::CTRL_CLK_SLEEP_BIT];
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            internal_rom_select <= next_internal_rom_select;
            cpu_idle <= next_cpu_idle;
            clock_sleep <= next_clock_sleep;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // Clock source and rate from the latched straps
    assign freq_reserved = strap_valid && (strap[1:0] != pin_strap_pkg::FREQ_24MHZ)
        && (strap[1:0] != pin_strap_pkg::FREQ_48MHZ);

    always_comb begin
        next_ext_clock_select = 1'b0;
        next_clock_48mhz_select = 1'b0;
        next_crystal_osc_enable = 1'b1;
        if (strap_valid) begin
            if (strap[pin_strap_pkg::CLKDRV_BIT] == pin_strap_pkg::CLKDRV_CRYSTAL) begin
                // Crystal is 24MHz only, the rate strap is ignored
                next_crystal_osc_enable = 1'b1;
            end else begin
                next_ext_clock_select = 1'b1;
                next_crystal_osc_enable = 1'b0;
                // Reserved codes fall back to 24MHz as the safer rate
                next_clock_48mhz_select = (strap[1:0] == pin_strap_pkg::FREQ_48MHZ);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ext_clock_select <= 1'b0;
            clock_48mhz_select <= 1'b0;
            crystal_osc_enable <= 1'b1;
        end else begin
            ext_clock_select <= next_ext_clock_select;
            clock_48mhz_select <= next_clock_48mhz_select;
            crystal_osc_enable <= next_crystal_osc_enable;
        end
    end

    // External program memory address and data
    always_comb begin
        next_addr_upper = cpu_addr[15:3];
        next_cpu_rdata = cpu_rdata;
        next_data_out = cpu_wdata;
        next_data_oe_n = 8'hff;
        if (!internal_rom_select) begin
            if (cpu_write) begin
                next_data_oe_n = 8'h00;
            end else begin
                next_cpu_rdata = prog_mem_data_bus_in;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            prog_mem_addr_upper <= 13'h0;
            cpu_rdata <= 8'h0;
            prog_mem_data_bus_out <= 8'h0;
            prog_mem_data_bus_oe_n <= 8'hff;
        end else begin
            prog_mem_addr_upper <= next_addr_upper;
            cpu_rdata <= next_cpu_rdata;
            prog_mem_data_bus_out <= next_data_out;
            prog_mem_data_bus_oe_n <= next_data_oe_n;
        end
    end
endmodule

// file: prog_mem_pin_ctrl_tb.sv
// Testbench for the strap and program memory pin block
`timescale 1ns/1ps
module prog_mem_pin_ctrl_tb;
    logic clk, reset, psel, penable, pwrite, pready, pslverr, wake_irq_line, cpu_write, strap_en;
    logic ext_clock_select, clock_48mhz_select, crystal_osc_enable;
    logic [7:0] paddr, cpu_wdata, cpu_rdata, prog_mem_data_bus_in, prog_mem_data_bus_out, prog_mem_data_bus_oe_n;
    logic [31:0] pwdata, prdata;
    logic [15:0] cpu_addr;
    logic [12:0] prog_mem_addr_upper;
    logic [2:0] prog_mem_addr_low_in, prog_mem_addr_low_out, prog_mem_addr_low_oe_n, strap_pulldown_en, strap_val, s;
    // Crystal cases with rate straps set check that the rate is ignored there
    logic [2:0] straps [7] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int miscompares, n_tests;
    prog_mem_pin_ctrl dut (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .wake_irq_line, .cpu_addr, .cpu_wdata, .cpu_write, .cpu_rdata, .prog_mem_addr_upper, .prog_mem_addr_low_in,
        .prog_mem_addr_low_out, .prog_mem_addr_low_oe_n, .strap_pulldown_en, .prog_mem_data_bus_in,
        .prog_mem_data_bus_out, .prog_mem_data_bus_oe_n, .ext_clock_select, .clock_48mhz_select, .crystal_osc_enable);
    ext_prog_mem mem_i (.clk(clk), .addr_upper(prog_mem_addr_upper), .addr_low(prog_mem_addr_low_out),
        .low_oe_n(prog_mem_addr_low_oe_n), .pd_on(strap_pulldown_en), .data_out(prog_mem_data_bus_out),
        .data_oe_n(prog_mem_data_bus_oe_n), .strap_en(strap_en), .strap_val(strap_val),
        .low_pin(prog_mem_addr_low_in), .data_pin(prog_mem_data_bus_in));
    always #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("Checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] exp,
        input logic err);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 10);
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 10) begin
            miscompares++;
            wrap_up;
        end else begin
            chk(pslverr, err);
            if (!wr) chk(prdata, exp);
        end
    endtask
    initial begin
        {clk, reset, psel, penable, pwrite, wake_irq_line, cpu_write, strap_en} = 8'h02;
        {paddr, cpu_wdata, pwdata, cpu_addr, strap_val} = '0;
        foreach (straps[k]) begin
            s = straps[k];
            reset <= 1'b1;
            strap_en <= s != 3'h0;
            strap_val <= s;
            repeat (4) @(posedge clk);
            chk(strap_pulldown_en, 3'h7);
            reset <= 1'b0;
            repeat (3) @(posedge clk);
            // Straps flip after release; latched selection must not follow
            strap_val <= ~s;
            chk(strap_pulldown_en, 3'h0);
            chk({ext_clock_select, clock_48mhz_select, crystal_osc_enable}, {s[2], s == 3'h7, !s[2]});
            apb(0, pin_strap_pkg::CTRL_OFFSET, 0, 32'h1, 0);
            apb(1, pin_strap_pkg::STATUS_OFFSET, 32'hff, 0, 0);
            apb(0, pin_strap_pkg::STATUS_OFFSET, 0, {24'h0, 2'h2, s[1] ^ s[0], s == 3'h7, s[2], s}, 0);
            apb(0, 8'h08, 0, 0, 1);
            apb(1, pin_strap_pkg::CTRL_OFFSET, 0, 0, 0);
            cpu_addr <= 16'h1234 + 16'(k * 9);
            cpu_wdata <= 8'ha5 + 8'(k);
            cpu_write <= 1'b1;
            @(posedge clk);
            cpu_write <= 1'b0;
            repeat (4) @(posedge clk);
            chk(cpu_rdata, 8'ha5 + 8'(k));
            chk(prog_mem_addr_upper, cpu_addr[15:3]);
            chk(prog_mem_addr_low_out, cpu_addr[2:0]);
            wake_irq_line <= 1'b0;
            apb(1, pin_strap_pkg::CTRL_OFFSET, 32'h6, 0, 0);
            repeat (3) @(posedge clk);
            chk(prog_mem_addr_low_oe_n, s);
            wake_irq_line <= 1'b1;
            repeat (3) @(posedge clk);
            chk(prog_mem_addr_low_oe_n, 3'h0);
            chk(ext_clock_select, s[2]);
        end
        wrap_up;
    end
endmodule
bind prog_mem_pin_ctrl prog_mem_pin_checker chk_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .wake_irq_line, .cpu_addr, .cpu_write, .prog_mem_addr_upper, .prog_mem_addr_low_in,
    .prog_mem_addr_low_out, .prog_mem_addr_low_oe_n, .strap_pulldown_en, .prog_mem_data_bus_oe_n,
    .ext_clock_select, .clock_48mhz_select, .crystal_osc_enable);
